// [logic/crc_step.sv]
// crc_step: advances a crc register over one dword, msb first
// assumes: caller holds the running value in its own register
`timescale 1ns/1ps
`default_nettype none
module crc_step #(
	parameter int W = 32,
	parameter logic [W-1:0] POLY = '1
) (
	// running value and next dword
	input wire logic [W-1:0] crc_in,
	input wire logic [31:0] data,
	// advanced value
	output logic [W-1:0] crc_out
);
	always_comb
	begin
		crc_out = crc_in;
		for (int i = 31; i >= 0; i--)
		begin
			if (crc_out[W-1] ^ data[i])
				crc_out = {crc_out[W-2:0], 1'b0} ^ POLY;
			else
				crc_out = {crc_out[W-2:0], 1'b0};
		end
	end
endmodule : crc_step
`default_nettype wire

// [logic/link_pkg.sv]
// link_pkg: constants, field positions and types shared by the port link logic
// assumes: one 125 MHz core clock and dword-wide streams on every side
package link_pkg;
	// clock and timing
	localparam int CLK_MHZ = 125;
	localparam int REPLAY_NS = 2000;
	localparam int REPLAY_CYC = (REPLAY_NS * CLK_MHZ + 999) / 1000;
	localparam int FC_NS = 30000;
	localparam int FC_CYC = (FC_NS * CLK_MHZ + 999) / 1000;
	localparam int TMR_W = 12;

	// sequence numbers, retry storage and port count
	localparam int SEQ_W = 12;
	typedef logic [SEQ_W-1:0] seq_t;
	localparam seq_t SEQ_ONE = 12'h001;
	localparam seq_t SEQ_RESET_ACKED = 12'hFFF;
	localparam int SLOTS = 4;
	localparam int SLOT_WORDS = 16;
	localparam int NPORTS = 4;

	// crc polynomials and seeds
	localparam logic [31:0] LCRC_POLY = 32'h04C11DB7;
	localparam logic [31:0] LCRC_INIT = 32'hFFFFFFFF;
	localparam logic [15:0] DCRC_POLY = 16'h100B;
	localparam logic [15:0] DCRC_INIT = 16'hFFFF;

	// dllp layout: type in the top byte, sequence or credits below
	localparam logic [7:0] DL_ACK = 8'h00;
	localparam logic [7:0] DL_NACK = 8'h10;
	localparam logic [7:0] DL_INITFC = 8'h40;
	localparam logic [7:0] DL_UPDFC = 8'h80;
	localparam int DL_TYPE_LSB = 24;
	localparam int FC_HDR_LSB = 14;

	// tlp header fields: dword 0, and the bus number in dword 2
	localparam int FMT_LSB = 29;
	localparam int TYPE_LSB = 24;
	localparam int TC_LSB = 20;
	localparam int TD_BIT = 15;
	localparam int BUS_LSB = 24;

	// tlp type codes and message routing codes
	localparam logic [4:0] TY_MEM = 5'h00;
	localparam logic [4:0] TY_MEMLK = 5'h01;
	localparam logic [4:0] TY_IO = 5'h02;
	localparam logic [4:0] TY_CFG0 = 5'h04;
	localparam logic [4:0] TY_CFG1 = 5'h05;
	localparam logic [4:0] TY_CPL = 5'h0A;
	localparam logic [4:0] TY_CPLLK = 5'h0B;
	localparam logic [1:0] TY_MSG_TOP = 2'h2;
	localparam logic [2:0] MR_RC = 3'h0;
	localparam logic [2:0] MR_ADDR = 3'h1;
	localparam logic [2:0] MR_ID = 3'h2;
	localparam logic [2:0] MR_BCAST = 3'h3;
	localparam logic [2:0] MR_LOCAL = 3'h4;
	localparam logic [2:0] MR_GATHER = 3'h5;
	localparam logic [NPORTS-1:0] UPSTREAM_MASK = 4'h1;

	typedef enum {TX_IDLE, TX_SEQ, TX_BODY, TX_CRC} tx_state_e;
endpackage : link_pkg

// [logic/pcie_port_link.sv]
// pcie_port_link: data link layer and receive transaction layer of one switch port
// assumes: mac delivers whole tlps and dllps as dword streams on core_clk,
// and the fabric sink takes every received word without back-pressure
//
// Behaviour
// - every tlp carries and checks 32-bit lcrc
// - bad received lcrc sends a nack
// - good received lcrc sends an ack
// - sent tlps held until acknowledged
// - ack releases all tlps up to its sequence
// - nack or timeout replays oldest onward, in order
// - credits initialised and updated only through dllps
// - every dllp carries and checks 16-bit crc
// - illegal header or length mismatch flags malformed
// - digest bit set means ecrc is checked
// - config, completions, id messages routed by id
// - memory and io routed by address window
// - system messages routed by the low three routing bits of their type field
// - no matching port means unsupported request
// - every traffic class maps to channel zero
`timescale 1ns/1ps
`default_nettype none
module pcie_port_link (
	// clock and reset
	input wire logic core_clk,
	input wire logic nrst,
	// received tlp words from the link: sequence word, tlp, lcrc
	input wire logic rx_valid,
	input wire logic [31:0] rx_data,
	input wire logic rx_sop,
	input wire logic rx_eop,
	// transmitted tlp words to the link
	output logic tx_valid,
	output logic [31:0] tx_data,
	output logic tx_sop,
	output logic tx_eop,
	input wire logic tx_ready,
	// received dllps
	input wire logic drx_valid,
	input wire logic [31:0] drx_data,
	input wire logic [15:0] drx_crc,
	// transmitted dllps
	output logic dtx_valid,
	output logic [31:0] dtx_data,
	output logic [15:0] dtx_crc,
	input wire logic dtx_ready,
	// tlps from the fabric to send
	input wire logic src_valid,
	input wire logic [31:0] src_data,
	input wire logic src_eop,
	output logic src_ready,
	// received tlps to the fabric, verdict in the same cycle as the last word and fab_eop
	output logic fab_valid,
	output logic [31:0] fab_data,
	output logic fab_sop,
	output logic fab_eop,
	output logic fab_done,
	output logic fab_good,
	output logic fab_malformed,
	output logic fab_ecrc_err,
	output logic fab_ur,
	output logic fab_local,
	output logic [link_pkg::NPORTS-1:0] fab_dest,
	output logic fab_vc,
	// routing windows of the ports
	input wire logic [31:0] port_mem_base [link_pkg::NPORTS],
	input wire logic [31:0] port_mem_limit [link_pkg::NPORTS],
	input wire logic [7:0] port_bus_lo [link_pkg::NPORTS],
	input wire logic [7:0] port_bus_hi [link_pkg::NPORTS],
	// credits
	input wire logic [7:0] adv_hdr_credit,
	input wire logic [11:0] adv_data_credit,
	output logic [7:0] far_hdr_credit,
	output logic [11:0] far_data_credit,
	output logic dllp_crc_err
);
	function automatic logic in_range(input logic [31:0] v, input logic [31:0] lo,
		input logic [31:0] hi);
		in_range = (v >= lo) && (v <= hi);
	endfunction : in_range

	function automatic logic legal_hdr(input logic [1:0] fmt, input logic [4:0] ty);
		legal_hdr = 1'b0;
		if (ty[4:3] == link_pkg::TY_MSG_TOP)
			legal_hdr = fmt[0];
		else
		begin
			case (ty)
				link_pkg::TY_MEM: legal_hdr = 1'b1;
				link_pkg::TY_MEMLK: legal_hdr = !fmt[1];
				link_pkg::TY_IO, link_pkg::TY_CFG0, link_pkg::TY_CFG1: legal_hdr = !fmt[0];
				link_pkg::TY_CPL, link_pkg::TY_CPLLK: legal_hdr = !fmt[0];
				default: legal_hdr = 1'b0;
			endcase
		end
	endfunction : legal_hdr

	// only one channel exists, so the class is read but never selects
	function automatic logic tc_to_vc(input logic [2:0] tc);
		tc_to_vc = 1'b0 & tc[0];
	endfunction : tc_to_vc

	////////////////////////////////////////////////////////////////////////////////
	// receive tlp path
	logic [31:0] rx_lcrc_q, rx_lcrc_nx, rx_ecrc_q, rx_ecrc_nx, rx_ecrc_lag_q;
	logic [31:0] hdr0_q, hdr2_q, hdr3_q, rx_prev_q;
	logic [10:0] rx_cnt_q, exp_words, len_words;
	logic rx_held_q;
	link_pkg::seq_t rx_seqw_q, rcv_seq_q;
	logic rx_end, lcrc_ok, seq_ok, malformed, ecrc_bad, is_local, ur;
	logic [1:0] fmt;
	logic [4:0] ty;
	logic [31:0] addr, bus;
	logic [link_pkg::NPORTS-1:0] addr_hit, id_hit, dest;

	crc_step #(.W(32), .POLY(link_pkg::LCRC_POLY)) u_rx_lcrc (
		.crc_in(rx_sop ? link_pkg::LCRC_INIT : rx_lcrc_q),
		.data(rx_data),
		.crc_out(rx_lcrc_nx)
	);
	crc_step #(.W(32), .POLY(link_pkg::LCRC_POLY)) u_rx_ecrc (
		.crc_in(rx_cnt_q == 11'h000 ? link_pkg::LCRC_INIT : rx_ecrc_q),
		.data(rx_data),
		.crc_out(rx_ecrc_nx)
	);

	assign rx_end = rx_valid && rx_eop && !rx_sop;
	assign lcrc_ok = rx_lcrc_q == rx_data;
	assign seq_ok = rx_seqw_q == rcv_seq_q;
	assign fmt = hdr0_q[link_pkg::FMT_LSB +: 2];
	assign ty = hdr0_q[link_pkg::TYPE_LSB +: 5];
	assign len_words = (hdr0_q[9:0] == 10'h000) ? 11'h400 : {1'b0, hdr0_q[9:0]};
	assign exp_words = (fmt[0] ? 11'h004 : 11'h003) + (fmt[1] ? len_words : 11'h000)
		+ {10'h000, hdr0_q[link_pkg::TD_BIT]};
	assign malformed = !legal_hdr(fmt, ty) || (rx_cnt_q != exp_words);
	assign ecrc_bad = hdr0_q[link_pkg::TD_BIT] && (rx_ecrc_lag_q != rx_prev_q);

	always_ff @(posedge core_clk)
	begin
		if (!nrst)
		begin
			rx_cnt_q <= 11'h000;
			rx_held_q <= 1'b0;
			rx_seqw_q <= '0;
			rx_lcrc_q <= link_pkg::LCRC_INIT;
			rx_ecrc_q <= link_pkg::LCRC_INIT;
			rx_ecrc_lag_q <= link_pkg::LCRC_INIT;
			hdr0_q <= 32'h00000000;
			hdr2_q <= 32'h00000000;
			hdr3_q <= 32'h00000000;
			rx_prev_q <= 32'h00000000;
		end
		else if (rx_valid)
		begin
			rx_lcrc_q <= rx_lcrc_nx;
			rx_cnt_q <= rx_sop ? 11'h000 : rx_cnt_q + 11'h001;
			rx_held_q <= !rx_sop && !rx_eop;
			if (rx_sop)
				rx_seqw_q <= rx_data[link_pkg::SEQ_W-1:0];
			if (!rx_sop && !rx_eop)
			begin
				rx_prev_q <= rx_data;
				rx_ecrc_q <= rx_ecrc_nx;
				rx_ecrc_lag_q <= rx_ecrc_q;
				if (rx_cnt_q == 11'h000)
					hdr0_q <= rx_data;
				if (rx_cnt_q == 11'h002)
					hdr2_q <= rx_data;
				if (rx_cnt_q == 11'h003)
					hdr3_q <= rx_data;
			end
		end
	end

	always_ff @(posedge core_clk)
	begin
		if (!nrst)
			rcv_seq_q <= '0;
		else if (rx_end && lcrc_ok && seq_ok)
			rcv_seq_q <= rcv_seq_q + link_pkg::SEQ_ONE;
	end

	////////////////////////////////////////////////////////////////////////////////
	// routing decision
	assign addr = fmt[0] ? hdr3_q : hdr2_q;
	assign bus = {24'h000000, hdr2_q[link_pkg::BUS_LSB +: 8]};

	generate
		for (genvar p = 0; p < link_pkg::NPORTS; p++)
		begin : g_port
			assign addr_hit[p] = in_range(addr, port_mem_base[p], port_mem_limit[p]);
			assign id_hit[p] = in_range(bus, {24'h000000, port_bus_lo[p]},
				{24'h000000, port_bus_hi[p]});
		end
	endgenerate

	always_comb
	begin
		dest = '0;
		is_local = 1'b0;
		if (ty[4:3] == link_pkg::TY_MSG_TOP)
		begin
			case (ty[2:0])
				link_pkg::MR_RC: dest = link_pkg::UPSTREAM_MASK;
				link_pkg::MR_ADDR: dest = addr_hit;
				link_pkg::MR_ID: dest = id_hit;
				link_pkg::MR_BCAST: dest = '1;
				link_pkg::MR_LOCAL, link_pkg::MR_GATHER: is_local = 1'b1;
				default: dest = '0;
			endcase
		end
		else if (ty == link_pkg::TY_MEM || ty == link_pkg::TY_MEMLK || ty == link_pkg::TY_IO)
			dest = addr_hit;
		else
			dest = id_hit;
	end

	assign ur = !is_local && (dest == '0);

	always_ff @(posedge core_clk)
	begin
		if (!nrst)
		begin
			fab_valid <= 1'b0;
			fab_data <= 32'h00000000;
			fab_sop <= 1'b0;
			fab_eop <= 1'b0;
		end
		else
		begin
			fab_valid <= rx_valid && !rx_sop && rx_held_q;
			fab_data <= rx_prev_q;
			fab_sop <= rx_cnt_q == 11'h001;
			fab_eop <= rx_eop;
		end
	end

	always_ff @(posedge core_clk)
	begin
		if (!nrst)
		begin
			fab_done <= 1'b0;
			fab_good <= 1'b0;
			fab_malformed <= 1'b0;
			fab_ecrc_err <= 1'b0;
			fab_ur <= 1'b0;
			fab_local <= 1'b0;
			fab_dest <= '0;
			fab_vc <= 1'b0;
		end
		else
		begin
			fab_done <= rx_end;
			fab_good <= rx_end && lcrc_ok && seq_ok && !malformed && !ecrc_bad;
			fab_malformed <= rx_end && lcrc_ok && malformed;
			fab_ecrc_err <= rx_end && lcrc_ok && ecrc_bad;
			fab_ur <= rx_end && lcrc_ok && !malformed && ur;
			fab_local <= is_local;
			fab_dest <= dest;
			fab_vc <= tc_to_vc(hdr0_q[link_pkg::TC_LSB +: 3]);
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// transmit tlp path with retry buffer
	link_pkg::tx_state_e tx_st_q;
	link_pkg::seq_t next_tx_q, acked_q, tx_seq_q, outstanding, ack_dist, ack_seq;
	logic [31:0] rb_mem_q [link_pkg::SLOTS*link_pkg::SLOT_WORDS];
	logic [3:0] rb_len_q [link_pkg::SLOTS];
	logic [31:0] tx_crc_q, tx_crc_nx, tx_word;
	logic [3:0] tx_cnt_q;
	logic tx_replay_q, replay_pend_q, out_ok, body_go, body_last;
	logic [link_pkg::TMR_W-1:0] replay_tmr_q;
	logic d_ok, is_ack, is_nack, ack_move, timeout;

	assign outstanding = next_tx_q - acked_q - link_pkg::SEQ_ONE;
	assign out_ok = !tx_valid || tx_ready;
	assign tx_word = tx_replay_q ? rb_mem_q[{tx_seq_q[1:0], tx_cnt_q}] : src_data;
	assign src_ready = (tx_st_q == link_pkg::TX_BODY) && !tx_replay_q && out_ok;
	assign body_go = (tx_st_q == link_pkg::TX_BODY) && out_ok && (tx_replay_q || src_valid);
	// a fabric tlp longer than one slot is cut at the slot end
	assign body_last = tx_replay_q ? (tx_cnt_q == rb_len_q[tx_seq_q[1:0]])
		: (src_eop || tx_cnt_q == 4'hF);

	crc_step #(.W(32), .POLY(link_pkg::LCRC_POLY)) u_tx_lcrc (
		.crc_in(tx_st_q == link_pkg::TX_SEQ ? link_pkg::LCRC_INIT : tx_crc_q),
		.data(tx_st_q == link_pkg::TX_SEQ ? {20'h00000, tx_seq_q} : tx_word),
		.crc_out(tx_crc_nx)
	);

	always_ff @(posedge core_clk)
	begin
		if (!nrst)
		begin
			tx_st_q <= link_pkg::TX_IDLE;
			tx_seq_q <= '0;
			tx_replay_q <= 1'b0;
			tx_cnt_q <= 4'h0;
			tx_crc_q <= link_pkg::LCRC_INIT;
			tx_valid <= 1'b0;
			tx_data <= 32'h00000000;
			tx_sop <= 1'b0;
			tx_eop <= 1'b0;
		end
		else
		begin
			if (tx_ready)
				tx_valid <= 1'b0;
			case (tx_st_q)
				link_pkg::TX_IDLE:
				begin
					if (replay_pend_q && outstanding != '0)
					begin
						tx_seq_q <= acked_q + link_pkg::SEQ_ONE;
						tx_replay_q <= 1'b1;
						tx_st_q <= link_pkg::TX_SEQ;
					end
					else if (src_valid && outstanding < link_pkg::seq_t'(link_pkg::SLOTS))
					begin
						tx_seq_q <= next_tx_q;
						tx_replay_q <= 1'b0;
						tx_st_q <= link_pkg::TX_SEQ;
					end
				end
				link_pkg::TX_SEQ:
				begin
					if (out_ok)
					begin
						tx_valid <= 1'b1;
						tx_data <= {20'h00000, tx_seq_q};
						tx_sop <= 1'b1;
						tx_eop <= 1'b0;
						tx_crc_q <= tx_crc_nx;
						tx_cnt_q <= 4'h0;
						tx_st_q <= link_pkg::TX_BODY;
					end
				end
				link_pkg::TX_BODY:
				begin
					if (body_go)
					begin
						tx_valid <= 1'b1;
						tx_data <= tx_word;
						tx_sop <= 1'b0;
						tx_crc_q <= tx_crc_nx;
						tx_cnt_q <= tx_cnt_q + 4'h1;
						if (body_last)
							tx_st_q <= link_pkg::TX_CRC;
					end
				end
				link_pkg::TX_CRC:
				begin
					if (out_ok)
					begin
						tx_valid <= 1'b1;
						tx_data <= tx_crc_q;
						tx_eop <= 1'b1;
						if (tx_replay_q && tx_seq_q + link_pkg::SEQ_ONE != next_tx_q)
						begin
							tx_seq_q <= tx_seq_q + link_pkg::SEQ_ONE;
							tx_st_q <= link_pkg::TX_SEQ;
						end
						else
							tx_st_q <= link_pkg::TX_IDLE;
					end
				end
				default: tx_st_q <= link_pkg::TX_IDLE;
			endcase
		end
	end

	always_ff @(posedge core_clk)
	begin
		if (body_go && !tx_replay_q)
		begin
			rb_mem_q[{tx_seq_q[1:0], tx_cnt_q}] <= src_data;
			if (body_last)
				rb_len_q[tx_seq_q[1:0]] <= tx_cnt_q;
		end
	end

	always_ff @(posedge core_clk)
	begin
		if (!nrst)
			next_tx_q <= '0;
		else if (body_go && body_last && !tx_replay_q)
			next_tx_q <= next_tx_q + link_pkg::SEQ_ONE;
	end

	////////////////////////////////////////////////////////////////////////////////
	// received dllps: acknowledgements and credits
	logic [15:0] drx_crc_calc;

	crc_step #(.W(16), .POLY(link_pkg::DCRC_POLY)) u_rx_dcrc (
		.crc_in(link_pkg::DCRC_INIT),
		.data(drx_data),
		.crc_out(drx_crc_calc)
	);

	assign d_ok = drx_valid && drx_crc_calc == drx_crc;
	assign is_ack = d_ok && drx_data[link_pkg::DL_TYPE_LSB +: 8] == link_pkg::DL_ACK;
	assign is_nack = d_ok && drx_data[link_pkg::DL_TYPE_LSB +: 8] == link_pkg::DL_NACK;
	assign ack_seq = drx_data[link_pkg::SEQ_W-1:0];
	assign ack_dist = ack_seq - acked_q;
	// stale or out-of-window sequence numbers release nothing
	assign ack_move = (is_ack || is_nack) && ack_dist != '0 && ack_dist <= outstanding;
	assign timeout = replay_tmr_q == link_pkg::TMR_W'(link_pkg::REPLAY_CYC);

	always_ff @(posedge core_clk)
	begin
		if (!nrst)
			acked_q <= link_pkg::SEQ_RESET_ACKED;
		else if (ack_move)
			acked_q <= ack_seq;
	end

	always_ff @(posedge core_clk)
	begin
		if (!nrst)
			replay_tmr_q <= '0;
		else if (ack_move || outstanding == '0 || timeout || is_nack)
			replay_tmr_q <= '0;
		else
			replay_tmr_q <= replay_tmr_q + 1'b1;
	end

	always_ff @(posedge core_clk)
	begin
		if (!nrst)
			replay_pend_q <= 1'b0;
		else if (is_nack || timeout)
			replay_pend_q <= 1'b1;
		else if (tx_st_q == link_pkg::TX_IDLE)
			replay_pend_q <= 1'b0;
	end

	always_ff @(posedge core_clk)
	begin
		if (!nrst)
		begin
			far_hdr_credit <= 8'h00;
			far_data_credit <= 12'h000;
			dllp_crc_err <= 1'b0;
		end
		else
		begin
			dllp_crc_err <= drx_valid && !d_ok;
			if (d_ok && (drx_data[link_pkg::DL_TYPE_LSB +: 8] == link_pkg::DL_INITFC
				|| drx_data[link_pkg::DL_TYPE_LSB +: 8] == link_pkg::DL_UPDFC))
			begin
				far_hdr_credit <= drx_data[link_pkg::FC_HDR_LSB +: 8];
				far_data_credit <= drx_data[11:0];
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// dllp transmit: nack, ack, then credit reports
	logic ack_pend_q, nack_pend_q, init_pend_q, fc_due, dl_take;
	logic [link_pkg::TMR_W-1:0] fc_tmr_q;
	logic [7:0] sent_hdr_q;
	logic [11:0] sent_data_q;
	logic [31:0] dl_word;
	logic [15:0] dl_crc;

	assign fc_due = fc_tmr_q == link_pkg::TMR_W'(link_pkg::FC_CYC)
		|| sent_hdr_q != adv_hdr_credit || sent_data_q != adv_data_credit;
	assign dl_take = (!dtx_valid || dtx_ready)
		&& (nack_pend_q || ack_pend_q || init_pend_q || fc_due);

	always_comb
	begin
		dl_word = {link_pkg::DL_UPDFC, 2'h0, adv_hdr_credit, 2'h0, adv_data_credit};
		if (nack_pend_q)
			dl_word = {link_pkg::DL_NACK, 12'h000, rcv_seq_q - link_pkg::SEQ_ONE};
		else if (ack_pend_q)
			dl_word = {link_pkg::DL_ACK, 12'h000, rcv_seq_q - link_pkg::SEQ_ONE};
		else if (init_pend_q)
			dl_word = {link_pkg::DL_INITFC, 2'h0, adv_hdr_credit, 2'h0, adv_data_credit};
	end

	crc_step #(.W(16), .POLY(link_pkg::DCRC_POLY)) u_tx_dcrc (
		.crc_in(link_pkg::DCRC_INIT),
		.data(dl_word),
		.crc_out(dl_crc)
	);

	always_ff @(posedge core_clk)
	begin
		if (!nrst)
			nack_pend_q <= 1'b0;
		else
			nack_pend_q <= (rx_end && !lcrc_ok) || (nack_pend_q && !dl_take);
	end

	always_ff @(posedge core_clk)
	begin
		if (!nrst)
			ack_pend_q <= 1'b0;
		else
			ack_pend_q <= (rx_end && lcrc_ok) || (ack_pend_q && !(dl_take && !nack_pend_q));
	end

	always_ff @(posedge core_clk)
	begin
		if (!nrst)
		begin
			init_pend_q <= 1'b1;
			fc_tmr_q <= '0;
			sent_hdr_q <= 8'h00;
			sent_data_q <= 12'h000;
		end
		else if (dl_take && !nack_pend_q && !ack_pend_q)
		begin
			init_pend_q <= 1'b0;
			fc_tmr_q <= '0;
			sent_hdr_q <= adv_hdr_credit;
			sent_data_q <= adv_data_credit;
		end
		else if (fc_tmr_q != link_pkg::TMR_W'(link_pkg::FC_CYC))
			fc_tmr_q <= fc_tmr_q + 1'b1;
	end

	always_ff @(posedge core_clk)
	begin
		if (!nrst)
		begin
			dtx_valid <= 1'b0;
			dtx_data <= 32'h00000000;
			dtx_crc <= 16'h0000;
		end
		else if (dl_take)
		begin
			dtx_valid <= 1'b1;
			dtx_data <= dl_word;
			dtx_crc <= dl_crc;
		end
		else if (dtx_ready)
			dtx_valid <= 1'b0;
	end

	////////////////////////////////////////////////////////////////////////////////
	// checks
	property p_nack_bad;
		@(posedge core_clk) disable iff (!nrst)
		rx_end && !lcrc_ok |=> nack_pend_q;
	endproperty
	a_nack_bad: assert property (p_nack_bad) else $error("bad lcrc left no nack");

	property p_ack_good;
		@(posedge core_clk) disable iff (!nrst)
		rx_end && lcrc_ok && seq_ok |=> ack_pend_q && rcv_seq_q == $past(rcv_seq_q) + 12'h001;
	endproperty
	a_ack_good: assert property (p_ack_good) else $error("good tlp not acked");

	property p_hold;
		@(posedge core_clk) disable iff (!nrst)
		outstanding <= 12'h004;
	endproperty
	a_hold: assert property (p_hold) else $error("retry window overrun");

	property p_release;
		@(posedge core_clk) disable iff (!nrst)
		ack_move |=> acked_q == $past(ack_seq);
	endproperty
	a_release: assert property (p_release) else $error("ack did not release");

	property p_replay;
		@(posedge core_clk) disable iff (!nrst)
		is_nack && outstanding != '0 && tx_st_q == link_pkg::TX_IDLE
			|=> ##[0:2] tx_replay_q && tx_st_q == link_pkg::TX_SEQ;
	endproperty
	a_replay: assert property (p_replay) else $error("nack did not start replay");

	property p_dcrc;
		@(posedge core_clk) disable iff (!nrst)
		drx_valid && !d_ok |=> dllp_crc_err && $stable(far_hdr_credit) && $stable(acked_q);
	endproperty
	a_dcrc: assert property (p_dcrc) else $error("bad dllp was used");

	property p_ur;
		@(posedge core_clk) disable iff (!nrst)
		fab_ur |-> fab_done && fab_dest == '0 && !fab_local;
	endproperty
	a_ur: assert property (p_ur) else $error("ur with a destination");

	property p_seq;
		@(posedge core_clk) disable iff (!nrst)
		tx_valid && tx_sop && !tx_replay_q |-> tx_data[11:0] == next_tx_q;
	endproperty
	a_seq: assert property (p_seq) else $error("new tlp sequence skipped");

	property p_vc;
		@(posedge core_clk) disable iff (!nrst)
		fab_done |-> !fab_vc;
	endproperty
	a_vc: assert property (p_vc) else $error("channel other than zero");
endmodule : pcie_port_link
`default_nettype wire

// [verif/link_partner.sv]
// link_partner: far port model, sinks tlps and dllps, sends dllps
// assumes: go is a one-cycle request raised at the falling edge
`timescale 1ns/1ps
`default_nettype none
module link_partner (
	// port side
	input wire logic core_clk,
	input wire logic tx_valid,
	input wire logic [31:0] tx_data,
	input wire logic tx_sop,
	input wire logic tx_eop,
	output logic tx_ready,
	input wire logic dtx_valid,
	input wire logic [31:0] dtx_data,
	input wire logic [15:0] dtx_crc,
	output logic dtx_ready,
	output logic drx_valid,
	output logic [31:0] drx_data,
	output logic [15:0] drx_crc,
	// bench side
	input wire logic go,
	input wire logic [31:0] word,
	input wire logic bad,
	input wire logic slow
);
	int dl_cnt, tx_cnt, tx_bad;
	logic [31:0] tx_crc;
	logic ph_q = 1'b0;
	logic dl_ok;
	logic [31:0] last_dl;
	logic [7:0][11:0] seq_hist;
	////////////////////////////////
	function automatic logic [15:0] crc16(input logic [31:0] d);
		logic [15:0] c = 16'hFFFF;
		for (int i = 31; i >= 0; i--)
			c = {c[14:0], 1'b0} ^ ((c[15] ^ d[i]) ? link_pkg::DCRC_POLY : 16'h0000);
		return c;
	endfunction : crc16
	function automatic logic [31:0] crc32(input logic [31:0] c, input logic [31:0] d);
		for (int i = 31; i >= 0; i--)
			c = {c[30:0], 1'b0} ^ ((c[31] ^ d[i]) ? link_pkg::LCRC_POLY : 32'h00000000);
		return c;
	endfunction : crc32
	// slow mode takes a tlp word only every other cycle
	assign tx_ready = ph_q | ~slow;
	assign dtx_ready = 1'b1;
	assign drx_valid = go;
	assign drx_data = go ? word : ~word;
	assign drx_crc = crc16(word) ^ {15'h0000, bad};
	always @(posedge core_clk)
	begin
		ph_q <= ~ph_q;
		if (dtx_valid)
			dl_cnt <= dl_cnt + 1;
		if (dtx_valid)
			{last_dl, dl_ok} <= {dtx_data, dtx_crc === crc16(dtx_data)};
		if (tx_valid && tx_ready && tx_sop)
			seq_hist[tx_cnt[2:0]] <= tx_data[11:0];
		if (tx_valid && tx_ready && tx_sop)
			tx_cnt <= tx_cnt + 1;
		if (tx_valid && tx_ready)
			tx_crc <= crc32(tx_sop ? link_pkg::LCRC_INIT : tx_crc, tx_data);
		if (tx_valid && tx_ready && tx_eop && tx_data !== tx_crc)
			tx_bad <= tx_bad + 1;
	end
endmodule : link_partner
`default_nettype wire

// [verif/pcie_port_link_tb_top.sv]
// pcie_port_link_tb_top: directed bench with a far port model
// assumes: inputs change at the falling edge of core_clk
`timescale 1ns/1ps
`default_nettype none
module pcie_port_link_tb_top;
	localparam logic [7:0] AK = link_pkg::DL_ACK;
	localparam logic [7:0] NK = link_pkg::DL_NACK;
	logic core_clk, nrst, rx_valid, rx_sop, rx_eop, tx_valid, tx_sop, tx_eop, tx_ready, go;
	logic drx_valid, dtx_valid, dtx_ready, src_valid, src_eop, src_ready, dllp_crc_err, bad;
	logic fab_valid, fab_sop, fab_eop, fab_done, fab_good, fab_malformed, fab_ecrc_err, fab_ur;
	logic fab_local, fab_vc, slow;
	logic crc_seen = 1'b0;
	logic [31:0] rx_data, tx_data, drx_data, dtx_data, src_data, fab_data, word;
	logic [15:0] drx_crc, dtx_crc;
	logic [3:0] fab_dest;
	logic [31:0] port_mem_base [4], port_mem_limit [4];
	logic [7:0] port_bus_lo [4], port_bus_hi [4], adv_hdr_credit, far_hdr_credit;
	logic [11:0] adv_data_credit, far_data_credit;
	int err_count, num_checks, cyc;
	pcie_port_link u_pcie_port_link (.*);
	link_partner u_link_partner (.*);
	////////////////////////////////
	initial
	begin
		core_clk = 1'b0;
		forever #4 core_clk = ~core_clk;
	end
	always @(posedge core_clk)
	begin
		crc_seen <= crc_seen | (dllp_crc_err === 1'b1);
		cyc++;
		if (cyc == 20000)
		begin
			err_count++;
			give_verdict();
		end
	end
	task automatic check(input string s, input logic [31:0] e, input logic [31:0] g);
		num_checks++;
		if (g !== e)
		begin
			err_count++;
			$display("MISMATCH %s expected %h seen %h", s, e, g);
		end
	endtask : check
	function automatic logic [31:0] crc32(input logic [31:0] c, input logic [31:0] d);
		for (int i = 31; i >= 0; i--)
			c = {c[30:0], 1'b0} ^ ((c[31] ^ d[i]) ? link_pkg::LCRC_POLY : 32'h00000000);
		return c;
	endfunction : crc32
	task automatic give_verdict;
		if (err_count == 0 && num_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : give_verdict
	task automatic send_dl(input logic [31:0] w, input logic b);
		{go, word, bad} = {1'b1, w, b};
		@(negedge core_clk);
		go = 1'b0;
		repeat (3) @(negedge core_clk);
	endtask : send_dl
	task automatic frame(input logic [11:0] sq, input logic [31:0] d0, input logic [31:0] d2,
		input logic bd, input logic [3:0] dst, input logic [1:0] um, input logic [19:0] dl);
		logic [31:0] w [5];
		int n;
		n = u_link_partner.dl_cnt;
		w = '{{20'h00000, sq}, d0, 32'h00000000, d2, link_pkg::LCRC_INIT};
		for (int i = 0; i < 4; i++)
			w[4] = crc32(w[4], w[i]);
		w[4][0] ^= bd;
		for (int i = 0; i < 5; i++)
		begin
			{rx_valid, rx_sop, rx_eop, rx_data} = {1'b1, i == 0, i == 4, w[i]};
			@(negedge core_clk);
		end
		rx_valid = 1'b0;
		for (int k = 0; k < 8 && fab_done !== 1'b1; k++)
			@(posedge core_clk) #1;
		check("ur", um[1], fab_ur);
		check("malformed", um[0], fab_malformed);
		check("vc", 0, fab_vc);
		check("ecrc", 0, fab_ecrc_err);
		check("local", 0, fab_local);
		check("last word", d2, fab_data);
		check("end mark", 2'h3, {fab_valid, fab_eop});
		if (dst != 0)
			check("dest", dst, fab_dest);
		if (um == 0)
			check("good", !bd, fab_good);
		for (int k = 0; k < 30 && u_link_partner.dl_cnt == n; k++)
			@(posedge core_clk) #1;
		check("dllp", dl, {u_link_partner.last_dl[31:24], u_link_partner.last_dl[11:0]});
		check("dllp crc", 1, u_link_partner.dl_ok);
		@(negedge core_clk);
	endtask : frame
	task automatic credits;
		for (int k = 0; k < 20 && u_link_partner.dl_cnt == 0; k++)
			@(negedge core_clk);
		check("initfc", link_pkg::DL_INITFC, u_link_partner.last_dl[31:24]);
		send_dl({link_pkg::DL_UPDFC, 2'h0, 8'h12, 2'h0, 12'h345}, 1'b0);
		check("credits", {8'h12, 12'h345}, {far_hdr_credit, far_data_credit});
		check("no crc error", 0, crc_seen);
		send_dl({link_pkg::DL_UPDFC, 2'h0, 8'h56, 2'h0, 12'h789}, 1'b1);
		check("credits kept", {8'h12, 12'h345}, {far_hdr_credit, far_data_credit});
		check("crc error", 1, crc_seen);
	endtask : credits
	task automatic rx_frames;
		frame(12'h000, 32'h00500001, 32'h00002000, 1'b0, 4'h4, 2'h0, {AK, 12'h000});
		frame(12'h001, 32'h00500001, 32'h00002000, 1'b1, 4'h0, 2'h0, {NK, 12'h000});
		frame(12'h001, 32'h00000001, 32'hF0000000, 1'b0, 4'h0, 2'h2, {AK, 12'h001});
		frame(12'h002, 32'h40000001, 32'h00002000, 1'b0, 4'h0, 2'h1, {AK, 12'h002});
		frame(12'h003, 32'h04000001, 32'h21000000, 1'b0, 4'h4, 2'h0, {AK, 12'h003});
	endtask : rx_frames
	task automatic src_word(input logic [31:0] d);
		{src_valid, src_eop, src_data} = {2'h3, d};
		for (int k = 0; k < 50 && src_ready !== 1'b1; k++)
			@(negedge core_clk);
		@(negedge core_clk);
		src_valid = 1'b0;
		@(negedge core_clk);
	endtask : src_word
	task automatic wait_tx(input int n);
		for (int k = 0; k < 700 && u_link_partner.tx_cnt < n; k++)
			@(negedge core_clk);
	endtask : wait_tx
	task automatic replay;
		slow = 1'b1;
		src_word(32'hA5A50001);
		src_word(32'h5A5A0002);
		wait_tx(2);
		check("seq", 24'h001000, u_link_partner.seq_hist[1:0]);
		send_dl({NK, 12'h000, 12'hFFF}, 1'b0);
		wait_tx(4);
		check("replay", 24'h001000, u_link_partner.seq_hist[3:2]);
		send_dl({AK, 12'h000, 12'h001}, 1'b0);
		repeat (400) @(negedge core_clk);
		check("released", 4, u_link_partner.tx_cnt);
		check("tx lcrc", 0, u_link_partner.tx_bad);
	endtask : replay
	initial
	begin
		{nrst, rx_valid, rx_sop, rx_eop, src_valid, src_eop, go, bad, slow} = 9'h000;
		{rx_data, src_data, word} = 96'h0;
		{adv_hdr_credit, adv_data_credit} = 20'h20100;
		for (int i = 0; i < 4; i++)
		begin
			port_mem_base[i] = 32'(i) << 12;
			port_mem_limit[i] = port_mem_base[i] + 32'h00000FFF;
			port_bus_lo[i] = 8'(i) << 4;
			port_bus_hi[i] = port_bus_lo[i] + 8'h0F;
		end
		repeat (2) @(posedge core_clk);
		@(negedge core_clk);
		nrst = 1'b1;
		credits();
		rx_frames();
		replay();
		give_verdict();
	end
endmodule : pcie_port_link_tb_top
`default_nettype wire
